/* design/fsc_pkg.sv */
/*
 * Constants, register map and state types for the flash security and
 * command status block.
 * Assumes a 100 MHz module clock and a word-addressed Avalon-MM slave.
 */
package fsc_pkg;
    // ----------------------------------------------------------------
    // Configuration field layout (array addresses 0xff00-0xff0f)
    // ----------------------------------------------------------------
    localparam logic [15:0] CFG_FIELD_BASE = 16'hff00;
    localparam logic [3:0] CFG_KEY_OFS = 4'h0;
    localparam logic [3:0] CFG_KEY_LEN = 4'h8;
    localparam logic [3:0] CFG_PROT_OFS = 4'hd;
    localparam logic [3:0] CFG_SEC_OFS = 4'hf;
    // Key bytes are arbitrary; protection open, secured with backdoor on
    localparam logic [127:0] CFG_INIT = 128'hbf_ff_ff_ff_ff_ff_ff_ff_8e_7d_6c_5b_4a_39_28_17;

    // ----------------------------------------------------------------
    // Register word indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [5:0] REG_CONFIG = 6'h00;
    localparam logic [5:0] REG_LOCK = 6'h01;
    localparam logic [5:0] REG_FTEST = 6'h02;
    localparam logic [5:0] REG_PROT = 6'h04;
    localparam logic [5:0] REG_STAT = 6'h05;
    localparam logic [5:0] REG_EVT = 6'h06;
    localparam logic [5:0] REG_EVT_CLR = 6'h07;
    localparam logic [5:0] REG_EVT_EN = 6'h08;
    localparam logic [5:0] REG_MODE = 6'h09;
    localparam logic [5:0] REG_KEY = 6'h0a;
    localparam logic [5:0] REG_ARRAY = 6'h0b;
    localparam logic [5:0] REG_CMD = 6'h0c;

    // ----------------------------------------------------------------
    // Field positions and codes
    // ----------------------------------------------------------------
    localparam int ST_BEF = 7;
    localparam int ST_CCF = 6;
    localparam int ST_PV = 5;
    localparam int ST_AE = 4;
    localparam int ST_BLANK = 2;
    localparam int ST_FAIL = 1;
    localparam int ST_DONE = 0;
    localparam int CFG_BEIE = 7;
    localparam int CFG_COMMAND_COMPLETE_IRQ_ENABLE = 6;
    localparam int PROT_OPEN = 7;
    localparam logic [1:0] BACKDOOR_ENABLE_FIELD_ON = 2'b10;
    localparam logic [1:0] SEC_UNSECURED = 2'b10;
    localparam logic [15:0] LOW_UNIT = 16'h0400;
    localparam logic [15:0] HIGH_UNIT = 16'h0800;
    localparam logic [15:0] BLANK_WORD = 16'hffff;

    // ----------------------------------------------------------------
    // Reset values and timing
    // ----------------------------------------------------------------
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [3:0] EVT_EN_RST = 4'h0;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CMD_TIME_NS = 1000;
    localparam logic [7:0] CMD_CYCLES = 8'((CMD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        FSC_LD_PROT = 2'b00,
        FSC_LD_SEC = 2'b01,
        FSC_READY = 2'b10
    } fsc_load_t;

    typedef enum logic [1:0] {
        FSC_SEQ_IDLE = 2'b00,
        FSC_SEQ_DATA = 2'b01,
        FSC_SEQ_CMD = 2'b10
    } fsc_seq_t;
endpackage : fsc_pkg

/* design/fsc_cfg_field.sv */
/*
 * Nonvolatile configuration field: sixteen bytes with one read port.
 * Assumes the contents are fixed at build time; read is combinational.
 */
`timescale 1ns/1ps
module fsc_cfg_field #(
    parameter logic [127:0] INIT = 128'h0
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] rd_addr_i,
    output logic [7:0] rd_data_o
);
    logic [7:0] mem_q [16];

    // Held in flops so the field behaves as a stored array
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 16; i++) begin
                mem_q[i] <= INIT[i*8 +: 8];
            end
        end
    end

    assign rd_data_o = mem_q[rd_addr_i];
endmodule : fsc_cfg_field

/* design/fsc_core.sv */
/*
 * Flash security decode, protection register and command status flags,
 * reached over an Avalon-MM slave with waitrequest.
 * Assumes one clock, a synchronous active-low reset and a well-behaved
 * master that holds each request until waitrequest is low.
 */
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
module fsc_core (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o
);
    import fsc_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    fsc_load_t ld_q;
    fsc_seq_t seq_q;
    logic [3:0] cfg_addr;
    logic [7:0] cfg_data;
    logic [7:0] prot_q;
    logic [7:0] lock_q;
    logic [7:0] config_q;
    logic mode_q;
    logic [3:0] evt_q;
    logic [3:0] evt_en_q;
    logic [3:0] key_idx_q;
    logic key_bad_q;
    logic bef_q;
    logic ccf_q;
    logic pv_q;
    logic ae_q;
    logic blank_q;
    logic fail_q;
    logic [15:0] addr_q;
    logic [15:0] data_q;
    logic pend_q;
    logic [15:0] pend_data_q;
    logic act_q;
    logic [15:0] act_data_q;
    logic [7:0] cnt_q;
    logic rd_ack_q;
    logic [31:0] rdata_q;
    logic irq_q;
    logic ready;
    logic wr;
    logic wr8;
    logic [7:0] wd;
    logic stat_wr;
    logic launch;
    logic launch_ok;
    logic abort;
    logic arr_wr;
    logic cmd_wr;
    logic seq_err;
    logic ae_set;
    logic pv_set;
    logic done;
    logic take_pend;
    logic key_wr;
    logic key_armed;
    logic secured;
    logic prot_ok;
    logic is_prot;
    logic [15:0] low_end;
    logic [15:0] high_start;
    logic [7:0] stat_rd;
    logic [31:0] rd_mux;
    logic [3:0] evt_set;
    logic bef_d;
    logic ccf_d;

    // ----------------------------------------------------------------
    // Configuration field and reset-time load
    // ----------------------------------------------------------------
    fsc_cfg_field #(
        .INIT(CFG_INIT)
    ) u_field (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .rd_addr_i(cfg_addr),
        .rd_data_o(cfg_data)
    );

    // Key bytes sit at the bottom of the field
    always_comb begin
        case (ld_q)
            FSC_LD_PROT: cfg_addr = CFG_PROT_OFS;
            FSC_LD_SEC: cfg_addr = CFG_SEC_OFS;
            default: cfg_addr = CFG_KEY_OFS + key_idx_q;
        endcase
    end

    // Bus stalls until both stored bytes are copied in
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            ld_q <= FSC_LD_PROT;
        end else begin
            case (ld_q)
                FSC_LD_PROT: ld_q <= FSC_LD_SEC;
                FSC_LD_SEC: ld_q <= FSC_READY;
                FSC_READY: ld_q <= FSC_READY;
                default: ld_q <= FSC_LD_PROT;
            endcase
        end
    end

    assign ready = (ld_q == FSC_READY);

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign wr = avs_write_i & ready;
    assign wr8 = wr & avs_byteenable_i[0];
    assign wd = avs_writedata_i[7:0];
    assign stat_wr = wr8 & (avs_address_i == REG_STAT);
    assign arr_wr = wr & (avs_byteenable_i == 4'hf) & (avs_address_i == REG_ARRAY);
    assign cmd_wr = wr8 & (avs_address_i == REG_CMD);
    assign key_wr = wr8 & (avs_address_i == REG_KEY);

    // ----------------------------------------------------------------
    // Security decode and backdoor key
    // ----------------------------------------------------------------
    assign secured = (lock_q[1:0] != SEC_UNSECURED);
    assign key_armed = (lock_q[7:6] == BACKDOOR_ENABLE_FIELD_ON) & secured;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            lock_q <= 8'h00;
        end else if (ld_q == FSC_LD_SEC) begin
            lock_q <= cfg_data;
        end else if (key_wr & key_armed & ~key_bad_q & (wd == cfg_data)
                     & (key_idx_q == CFG_KEY_LEN - 4'h1)) begin
            lock_q[1:0] <= SEC_UNSECURED;
        end
    end

    // A wrong byte spoils the attempt until all eight are written
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            key_idx_q <= 4'h0;
            key_bad_q <= 1'b0;
        end else if (key_wr & key_armed) begin
            if (key_idx_q == CFG_KEY_LEN - 4'h1) begin
                key_idx_q <= 4'h0;
                key_bad_q <= 1'b0;
            end else begin
                key_idx_q <= key_idx_q + 4'h1;
                key_bad_q <= key_bad_q | (wd != cfg_data);
            end
        end
    end

    // ----------------------------------------------------------------
    // Protection register and area check
    // ----------------------------------------------------------------
    always_comb begin
        case (prot_q[2:0])
            3'd7: prot_ok = 1'b1;
            3'd6: prot_ok = (wd[2:0] == 3'd1) | (wd[2:0] == 3'd3) | (wd[2:0] == 3'd4)
                            | (wd[2:0] == 3'd6);
            default: prot_ok = (wd[2:0] == prot_q[2:0]);
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            prot_q <= 8'h00;
        end else if (ld_q == FSC_LD_PROT) begin
            prot_q <= cfg_data;
        end else if (wr8 & (avs_address_i == REG_PROT) & prot_ok) begin
            prot_q <= wd;
        end
    end

    // Scenario bits: 0 lower, 1 higher, 2 remaining; a one leaves it open
    assign low_end = LOW_UNIT << prot_q[6:5];
    assign high_start = 16'(BLANK_WORD - (HIGH_UNIT << prot_q[4:3]) + 16'h0001);

    always_comb begin
        if (!prot_q[PROT_OPEN]) begin
            is_prot = 1'b1;
        end else if (addr_q < low_end) begin
            is_prot = ~prot_q[0];
        end else if (addr_q >= high_start) begin
            is_prot = ~prot_q[1];
        end else begin
            is_prot = ~prot_q[2];
        end
    end

    // ----------------------------------------------------------------
    // Command write sequence
    // ----------------------------------------------------------------
    assign launch = stat_wr & wd[ST_BEF] & bef_q;
    assign launch_ok = launch & (seq_q == FSC_SEQ_CMD) & ~ae_q & ~pv_q & ~is_prot;
    assign abort = stat_wr & ~wd[ST_BEF] & (seq_q != FSC_SEQ_IDLE);
    assign seq_err = (arr_wr & (~bef_q | (seq_q != FSC_SEQ_IDLE) | avs_writedata_i[16]))
                   | (cmd_wr & (seq_q != FSC_SEQ_DATA));
    assign pv_set = launch & (seq_q == FSC_SEQ_CMD) & ~ae_q & ~pv_q & is_prot;
    assign ae_set = abort | seq_err | (launch & ~launch_ok & ~pv_set);

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            seq_q <= FSC_SEQ_IDLE;
        end else if (abort | seq_err | launch) begin
            seq_q <= FSC_SEQ_IDLE;
        end else if (arr_wr) begin
            seq_q <= FSC_SEQ_DATA;
        end else if (cmd_wr) begin
            seq_q <= FSC_SEQ_CMD;
        end
    end

    // Address in the upper half, data in the lower half
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            addr_q <= 16'h0000;
            data_q <= 16'h0000;
        end else if (arr_wr & ~seq_err) begin
            addr_q <= avs_writedata_i[31:16];
            data_q <= avs_writedata_i[15:0];
        end
    end

    // ----------------------------------------------------------------
    // One pending slot and one active command
    // ----------------------------------------------------------------
    assign done = act_q & (cnt_q == 8'h00);
    assign take_pend = pend_q & (~act_q | done);

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            pend_q <= 1'b0;
            pend_data_q <= 16'h0000;
        end else if (launch_ok) begin
            pend_q <= 1'b1;
            pend_data_q <= data_q;
        end else if (take_pend) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            act_q <= 1'b0;
            act_data_q <= 16'h0000;
            cnt_q <= 8'h00;
        end else if (take_pend) begin
            act_q <= 1'b1;
            act_data_q <= pend_data_q;
            cnt_q <= CMD_CYCLES - 8'h01;
        end else if (done) begin
            act_q <= 1'b0;
        end else if (act_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    always_comb begin
        bef_d = bef_q;
        if (launch_ok) begin
            bef_d = 1'b0;
        end else if (take_pend) begin
            bef_d = 1'b1;
        end
    end

    // Fetching a pending command does not count as completion
    always_comb begin
        ccf_d = ccf_q;
        if (~bef_q | launch_ok) begin
            ccf_d = 1'b0;
        end else if (done & ~pend_q) begin
            ccf_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            bef_q <= 1'b1;
            ccf_q <= 1'b1;
        end else begin
            bef_q <= bef_d;
            ccf_q <= ccf_d;
        end
    end

    // Error flags: a new error wins over a clearing write
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            pv_q <= 1'b0;
            ae_q <= 1'b0;
        end else begin
            pv_q <= pv_set | (pv_q & ~(stat_wr & wd[ST_PV]));
            ae_q <= ae_set | (ae_q & ~(stat_wr & wd[ST_AE]));
        end
    end

    // Failure is only set and cleared in special mode
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            fail_q <= 1'b0;
            blank_q <= 1'b0;
        end else begin
            fail_q <= (mode_q & pv_set)
                    | (fail_q & ~(mode_q & stat_wr & wd[ST_FAIL]));
            if (launch_ok) begin
                blank_q <= 1'b0;
            end else if (done) begin
                blank_q <= (act_data_q == BLANK_WORD);
            end
        end
    end

    always_comb begin
        stat_rd = 8'h00;
        stat_rd[ST_BEF] = bef_q;
        stat_rd[ST_CCF] = ccf_q;
        stat_rd[ST_PV] = pv_q;
        stat_rd[ST_AE] = ae_q;
        stat_rd[ST_BLANK] = blank_q;
        stat_rd[ST_FAIL] = mode_q & fail_q;
        stat_rd[ST_DONE] = mode_q & ~act_q & ~pend_q;
    end

    // ----------------------------------------------------------------
    // Control registers and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            config_q <= CONFIG_RST;
            mode_q <= 1'b0;
            evt_en_q <= EVT_EN_RST;
        end else if (wr8) begin
            if (avs_address_i == REG_CONFIG) begin
                config_q <= wd;
            end
            if (avs_address_i == REG_MODE) begin
                mode_q <= wd[0];
            end
            if (avs_address_i == REG_EVT_EN) begin
                evt_en_q <= wd[3:0];
            end
        end
    end

    assign evt_set = {pv_set, ae_set, ~ccf_q & ccf_d, ~bef_q & bef_d};

    // Set wins over a clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            evt_q <= 4'h0;
        end else if (wr8 & (avs_address_i == REG_EVT_CLR)) begin
            evt_q <= (evt_q & ~wd[3:0]) | evt_set;
        end else begin
            evt_q <= evt_q | evt_set;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (|(evt_q & evt_en_q))
                   | (bef_q & config_q[CFG_BEIE])
                   | (ccf_q & config_q[CFG_COMMAND_COMPLETE_IRQ_ENABLE]);
        end
    end

    assign irq_o = irq_q;

    // ----------------------------------------------------------------
    // Read path: one stall cycle, data from a flop
    // ----------------------------------------------------------------
    always_comb begin
        case (avs_address_i)
            REG_CONFIG: rd_mux = {24'h000000, config_q};
            REG_LOCK: rd_mux = {24'h000000, lock_q};
            REG_FTEST: rd_mux = 32'h00000000;
            REG_PROT: rd_mux = {24'h000000, prot_q};
            REG_STAT: rd_mux = {24'h000000, stat_rd};
            REG_EVT: rd_mux = {28'h0000000, evt_q};
            REG_EVT_EN: rd_mux = {28'h0000000, evt_en_q};
            REG_MODE: rd_mux = {31'h00000000, mode_q};
            REG_ARRAY: rd_mux = {addr_q, data_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rd_ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            rd_ack_q <= avs_read_i & ~rd_ack_q & ready;
            if (avs_read_i & ~rd_ack_q & ready) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = ~ready | (avs_read_i & ~rd_ack_q);
endmodule : fsc_core

/* verif/fsc_core_chk.sv */
/* Port checker for fsc_core.
   Assumes it is bound to fsc_core and that the mode register resets to normal. */
`timescale 1ns/1ps
module fsc_core_chk
    import fsc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic irq_o
);
    // ----------------------------------------
    // Shadow of enables written by software
    // ----------------------------------------
    logic [7:0] cfg_q;
    logic [3:0] en_q;
    logic spc_q;
    logic wr_w;
    logic rd_w;
    assign wr_w = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    assign rd_w = avs_read_i && !avs_waitrequest_o;
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            cfg_q <= CONFIG_RST;
            en_q <= EVT_EN_RST;
            spc_q <= 1'b0;
        end else if (wr_w) begin
            if (avs_address_i == REG_CONFIG) cfg_q <= avs_writedata_i[7:0];
            if (avs_address_i == REG_EVT_EN) en_q <= avs_writedata_i[3:0];
            if (avs_address_i == REG_MODE) spc_q <= avs_writedata_i[0];
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_load_wait: assert property ($rose(reset_n_i) |-> avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus served during load");
    chk_write_nowait: assert property (avs_write_i && $past(reset_n_i, 2) |-> !avs_waitrequest_o)
        else $error("write stalled after load");
    chk_read_onewait: assert property ($rose(avs_read_i) && $past(reset_n_i, 2)
        |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("read wait not one cycle");
    chk_rdata_stands: assert property (!(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
        else $error("read data moved");
    chk_ftest_zero: assert property (rd_w && avs_address_i == REG_FTEST |-> avs_readdata_o == 32'h0)
        else $error("test location not zero");
    chk_stat_unused: assert property (rd_w && avs_address_i == REG_STAT && !spc_q
        |-> avs_readdata_o[3] == 1'b0 && avs_readdata_o[1:0] == 2'h0)
        else $error("status spare bits set");
    chk_irq_masked: assert property (cfg_q[7:6] == 2'h0 && en_q == 4'h0 |=> !irq_o)
        else $error("irq with all enables off");
    chk_cfg_back: assert property (rd_w && avs_address_i == REG_CONFIG
        |-> avs_readdata_o[7:6] == cfg_q[7:6])
        else $error("irq enables lost");
endmodule : fsc_core_chk
bind fsc_core fsc_core_chk chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));

/* verif/fsc_cpu_model.sv */
/* Avalon-MM master standing in for the CPU.
   Assumes one clock; the bench calls its tasks and bounds every wait. */
`timescale 1ns/1ps
module fsc_cpu_model (
    input wire logic mclk_i,
    input wire logic wait_i,
    input wire logic [31:0] rdata_i,
    output logic [5:0] addr_o,
    output logic read_o,
    output logic write_o,
    output logic [31:0] wdata_o,
    output logic [3:0] be_o
);
    // ----------------------------------------
    // Bus cycles, held until waitrequest low
    // ----------------------------------------
    initial begin
        addr_o = 6'h0;
        read_o = 1'b0;
        write_o = 1'b0;
        wdata_o = 32'h0;
        be_o = 4'hf;
    end
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        wdata_o <= d;
        write_o <= 1'b1;
        do @(posedge mclk_i); while (wait_i !== 1'b0);
        write_o <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        read_o <= 1'b1;
        do @(posedge mclk_i); while (wait_i !== 1'b0);
        d = rdata_i;
        read_o <= 1'b0;
    endtask : rd
endmodule : fsc_cpu_model

/* verif/testbench.sv */
/* Register-level bench for fsc_core.
   Assumes the default configuration field of the package. */
`timescale 1ns/1ps
module testbench;
    import fsc_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [5:0] addr;
    logic rd_s;
    logic wr_s;
    logic [31:0] wdat;
    logic [3:0] be;
    logic [31:0] rdat;
    logic wt;
    logic irq_o;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0;
    logic [2:0] bad[4] = '{3'd0, 3'd2, 3'd5, 3'd7};
    always #5 mclk_i = ~mclk_i;
    fsc_cpu_model cpu (.mclk_i(mclk_i), .wait_i(wt), .rdata_i(rdat), .addr_o(addr), .read_o(rd_s),
        .write_o(wr_s), .wdata_o(wdat), .be_o(be));
    fsc_core dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .avs_address_i(addr), .avs_read_i(rd_s),
        .avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .irq_o(irq_o));
    // ----------------------------------------
    // Compare and helper tasks
    // ----------------------------------------
    task automatic chk8(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
        tests_run++;
        if ((g & m) !== (e & m)) begin
            n_errors++;
            $display("[FAIL] %0t byte %h expected %h", $time, g, e);
        end
    endtask : chk8
    task automatic chk1(input logic g, input logic e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t flag %b expected %b", $time, g, e);
        end
    endtask : chk1
    task automatic rc(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        logic [31:0] d;
        cpu.rd(a, d);
        chk8(d[7:0], e, m);
    endtask : rc
    task automatic run(input logic [15:0] a, input logic [15:0] d);
        cpu.wr(REG_ARRAY, {a, d});
        cpu.wr(REG_CMD, 32'h20);
        cpu.wr(REG_STAT, 32'h80);
    endtask : run
    task automatic poll();
        logic [31:0] d;
        d = '0;
        for (int i = 0; i < 300 && d[ST_CCF] !== 1'b1; i++) cpu.rd(REG_STAT, d);
    endtask : poll
    task automatic finish_test();
        $display("errors %0d comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    // Hang guard, well above the few hundred cycles needed
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 8000) begin
            n_errors++;
            finish_test();
        end
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rc(REG_LOCK, 8'hbf);
        rc(REG_PROT, 8'hff);
        rc(REG_STAT, 8'hc0);
        cpu.wr(REG_FTEST, 32'hff);
        rc(REG_FTEST, 8'h00);
        rc(6'h3f, 8'h00);
        cpu.wr(REG_STAT, 32'h40);
        cpu.wr(REG_STAT, 32'h00);
        rc(REG_STAT, 8'hc0);
        cpu.wr(REG_EVT_CLR, 32'hf);
        cpu.wr(REG_ARRAY, 32'h8000_1234);
        cpu.wr(REG_STAT, 32'h00);
        rc(REG_STAT, 8'hd0);
        cpu.wr(REG_EVT_EN, 32'h4);
        rc(REG_EVT, 8'h04, 8'h04);
        chk1(irq_o, 1'b1);
        cpu.wr(REG_EVT_EN, 32'h0);
        rc(REG_LOCK, 8'hbf);
        chk1(irq_o, 1'b0);
        cpu.wr(REG_EVT_EN, 32'h4);
        cpu.wr(REG_EVT_CLR, 32'h4);
        rc(REG_EVT, 8'h00, 8'h04);
        chk1(irq_o, 1'b0);
        cpu.wr(REG_EVT_EN, 32'h0);
        cpu.wr(REG_STAT, 32'h10);
        rc(REG_STAT, 8'hc0);
        cpu.wr(REG_CONFIG, 32'h80);
        rc(REG_LOCK, 8'hbf);
        chk1(irq_o, 1'b1);
        // Two launches back to back: complete only after both
        cpu.wr(REG_CONFIG, 32'h40);
        run(16'h8000, 16'h1234);
        t0 = cyc;
        rc(REG_STAT, 8'h80, 8'hc0);
        chk1(irq_o, 1'b0);
        run(16'h8002, 16'hffff);
        poll();
        chk1((cyc - t0) > 150, 1'b1);
        rc(REG_STAT, 8'hc4);
        chk1(irq_o, 1'b1);
        cpu.wr(REG_CONFIG, 32'h00);
        for (int k = 0; k < 16; k++) cpu.wr(REG_KEY, {24'h0, (k == 0) ? 8'h00 : CFG_INIT[8 * (k % 8) +: 8]});
        rc(REG_LOCK, 8'hbe);
        cpu.wr(REG_MODE, 32'h1);
        rc(REG_STAT, 8'hc1, 8'hfb);
        cpu.wr(REG_PROT, 32'h7e);
        rc(REG_PROT, 8'h7e);
        foreach (bad[i]) begin
            cpu.wr(REG_PROT, {24'h0, 5'h0f, bad[i]});
            rc(REG_PROT, 8'h7e);
        end
        run(16'h8000, 16'h0000);
        rc(REG_STAT, 8'he3, 8'heb);
        cpu.wr(REG_STAT, 32'h33);
        rc(REG_STAT, 8'hc1, 8'hfb);
        cpu.wr(REG_PROT, 32'h7c);
        rc(REG_PROT, 8'h7c);
        // Array open again: lower and higher guarded, remaining free
        cpu.wr(REG_PROT, 32'hfc);
        rc(REG_PROT, 8'hfc);
        run(16'h0000, 16'h0000);
        rc(REG_STAT, 8'he0, 8'hf0);
        cpu.wr(REG_STAT, 32'h33);
        run(16'hfffe, 16'h0000);
        rc(REG_STAT, 8'he0, 8'hf0);
        cpu.wr(REG_STAT, 32'h33);
        run(16'h8000, 16'h0000);
        rc(REG_STAT, 8'h80, 8'hf0);
        poll();
        finish_test();
    end
endmodule : testbench
